// >>> sac_adc_ctrl.sv
`timescale 1ns/1ps
// Function
// - Twelve-bit search, top bit first, bottom last.
// - Conversion clock sixteen per sample, at most 16 MHz.
// - Full resolution at the highest sample rate.
// - Start by software bit or frame-start trigger.
// - Continuous mode repeats without the trigger once one trigger starts it.
// - No start before the ready wait elapses.
// - Completion sets status and frame-end output.
// - Frame-end holds until the result is read.
// - Frame-end usable for interrupt or DMA request.
// - Mode bit selects continuous or one per trigger.
// - DMA moves continuous results without CPU help.
module sac_adc_ctrl
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic swStart,
  input wire logic frameStart,
  input wire logic oneShot,
  input wire logic wakeUp,
  input wire logic cmpIn,
  input wire logic resultRead,
  output logic [RES_BITS-1:0] dacCode,
  output logic [RES_BITS-1:0] result,
  output logic convBusy,
  output logic doneStatus,
  output logic frameEnd,
  output logic adcReady
);

  sac_conv_if cv ();

  logic [3:0] divQ;
  logic [8:0] waitQ;
  logic readyQ;
  logic runQ;
  logic trig;
  logic startNow;
  logic [RES_BITS-1:0] resultQ;
  logic doneQ;
  logic eofQ;

  // ************************************************************
  // Conversion clock enable.
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divQ <= 4'h0;
    end else if (clkEn) begin
      divQ <= (divQ == DIV_LAST) ? 4'h0 : divQ + 4'h1;
    end
  end

  assign cv.en = clkEn;
  assign cv.tick = (divQ == DIV_LAST);
  assign cv.cmp = cmpIn;

  // ************************************************************
  // Power-up and wake wait.
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitQ <= 9'h000;
      readyQ <= 1'b0;
    end else if (clkEn) begin
      if (wakeUp) begin
        waitQ <= 9'h000;
        readyQ <= 1'b0;
      end else if (!readyQ) begin
        if (waitQ == WAIT_LAST) begin
          readyQ <= 1'b1;
        end else begin
          waitQ <= waitQ + 9'h001;
        end
      end
    end
  end

  // ************************************************************
  // Start sources and mode.
  // ************************************************************
  assign trig = swStart | frameStart;
  assign startNow = clkEn && readyQ && !cv.busy && (trig || (runQ && !oneShot));
  assign cv.start = startNow;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      runQ <= 1'b0;
    end else if (clkEn) begin
      if (oneShot || wakeUp || !readyQ) begin
        runQ <= 1'b0;
      end else if (trig) begin
        runQ <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Result, status and frame-end.
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultQ <= CODE_RESET;
    end else if (clkEn && cv.done) begin
      resultQ <= cv.code;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneQ <= 1'b0;
      eofQ <= 1'b0;
    end else if (clkEn) begin
      if (cv.done) begin
        doneQ <= 1'b1;
        eofQ <= 1'b1;
      end else if (resultRead) begin
        doneQ <= 1'b0;
        eofQ <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dacCode <= CODE_RESET;
      convBusy <= 1'b0;
    end else if (clkEn) begin
      dacCode <= cv.code;
      convBusy <= cv.busy || startNow;
    end
  end

  assign result = resultQ;
  assign doneStatus = doneQ;
  assign frameEnd = eofQ;
  assign adcReady = readyQ;

  sac_sar_engine u_engine (
    .clk(clk),
    .sys_rst(sys_rst),
    .cv(cv)
  );

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ************************************************************
  // Enabled cycles from an accepted start to its completion.
  // ************************************************************
  logic [5:0] convCyc;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      convCyc <= 6'h00;
    end else if (clkEn) begin
      if (startNow) begin
        convCyc <= 6'h01;
      end else if (cv.busy && convCyc != 6'h3f) begin
        convCyc <= convCyc + 6'h01;
      end
    end
  end

  a_tick_rate: assert property (cv.tick && clkEn |=> !cv.tick)
    else $error("Conversion tick faster than allowed.");

  a_wait_block: assert property (!readyQ |-> !startNow)
    else $error("Conversion started before ready.");

  a_wait_length: assert property ($rose(readyQ) |-> $past(waitQ) == WAIT_LAST)
    else $error("Ready wait length wrong.");

  a_start_sources: assert property (clkEn && readyQ && !cv.busy && trig |=> cv.busy)
    else $error("Start request not taken.");

  a_eof_set: assert property (clkEn && cv.done |=> frameEnd && doneStatus)
    else $error("Completion did not set status and frame-end.");

  a_eof_hold: assert property (frameEnd && !(clkEn && resultRead) |=> frameEnd)
    else $error("Frame-end dropped before read.");

  a_eof_clear: assert property (clkEn && resultRead && !cv.done |=> !frameEnd)
    else $error("Frame-end not cleared by read.");

  a_cont_restart: assert property (clkEn && cv.done && runQ && !oneShot && readyQ
    |=> cv.busy)
    else $error("Continuous mode did not restart.");

  a_single_conv: assert property (clkEn && cv.done && oneShot && !trig |=> !cv.busy)
    else $error("Single mode converted without a trigger.");

  a_conv_time: assert property (clkEn && cv.done |->
    convCyc >= 6'((TICKS_PER_CONV - 1) * CONV_DIV + 2) && convCyc <= 6'(TICKS_PER_CONV * CONV_DIV + 1))
    else $error("Conversion length in enabled cycles is wrong.");

  a_freeze_state: assert property (!clkEn |=> $stable(divQ) && $stable(waitQ)
    && $stable(runQ) && $stable(eofQ) && $stable(dacCode))
    else $error("State moved while the clock enable was low.");

  a_busy_flag: assert property (startNow |=> convBusy)
    else $error("Busy flag not raised by an accepted start.");

  a_result_load: assert property (clkEn && cv.done |=> result == $past(cv.code))
    else $error("Result not loaded at completion.");

  a_dac_follow: assert property (clkEn |=> dacCode == $past(cv.code))
    else $error("Trial code output does not follow the search.");

  a_wake_drop: assert property (clkEn && wakeUp |=> !adcReady && !runQ)
    else $error("Wake did not restart the ready wait.");

  a_mode_stop: assert property (clkEn && oneShot |=> !runQ)
    else $error("Single mode left the run flag set.");

  c_single: cover property (oneShot && clkEn && cv.done);
  c_cont: cover property (runQ && clkEn && cv.done ##1 cv.busy);
  c_read: cover property (frameEnd && resultRead);
  c_wake: cover property (wakeUp ##1 !readyQ);
  c_freeze: cover property (!clkEn && cv.busy);

endmodule

// >>> sac_pkg.sv
package sac_pkg;

  // ************************************************************
  // Resolution and conversion timing.
  // ************************************************************
  localparam int RES_BITS = 12;
  localparam int TICKS_PER_CONV = 16;
  localparam int SAMPLE_TICKS = 1;
  localparam int TAIL_TICKS = TICKS_PER_CONV - SAMPLE_TICKS - RES_BITS;
  localparam logic [3:0] MSB_IDX = 4'hb;
  localparam logic [3:0] LSB_IDX = 4'h0;
  localparam logic [3:0] TAIL_LAST = 4'(TAIL_TICKS - 1);
  localparam logic [RES_BITS-1:0] CODE_RESET = 12'h000;

  // ************************************************************
  // Clock rates and derived counts.
  // ************************************************************
  localparam int SYS_CLK_KHZ = 25000;
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int CONV_CLK_MAX_KHZ = 16000;
  localparam int CONV_DIV = (SYS_CLK_KHZ + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ;
  localparam logic [3:0] DIV_LAST = 4'(CONV_DIV - 1);
  localparam int READY_WAIT_NS = 10000;
  localparam int READY_WAIT_CYC = (READY_WAIT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [8:0] WAIT_LAST = 9'(READY_WAIT_CYC - 1);

  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_BITS, SAC_TAIL} sac_state_t;

  // One-hot mask of a result bit.
  function automatic logic [RES_BITS-1:0] sacBitMask(input logic [3:0] idx);
    sacBitMask = 12'h001 << idx;
  endfunction

endpackage

// >>> sac_conv_if.sv
`timescale 1ns/1ps
interface sac_conv_if;
  logic en;
  logic start;
  logic tick;
  logic cmp;
  logic busy;
  logic done;
  logic [11:0] code;
  modport ctrl (output en, output start, output tick, output cmp,
                input busy, input done, input code);
  modport eng (input en, input start, input tick, input cmp,
               output busy, output done, output code);
endinterface

// >>> sac_sar_engine.sv
`timescale 1ns/1ps
module sac_sar_engine
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  sac_conv_if.eng cv
);

  sac_state_t stateQ;
  logic [3:0] idxQ;
  logic [RES_BITS-1:0] codeQ;
  logic doneQ;

  assign cv.busy = (stateQ != SAC_IDLE);
  assign cv.done = doneQ;
  assign cv.code = codeQ;

  // ************************************************************
  // Binary search from the top bit down to bit zero.
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= SAC_IDLE;
      idxQ <= 4'h0;
      codeQ <= CODE_RESET;
      doneQ <= 1'b0;
    end else if (cv.en) begin
      doneQ <= 1'b0;
      unique case (stateQ)
        SAC_IDLE: begin
          if (cv.start) begin
            stateQ <= SAC_SAMPLE;
            codeQ <= CODE_RESET;
          end
        end
        SAC_SAMPLE: begin
          if (cv.tick) begin
            stateQ <= SAC_BITS;
            idxQ <= MSB_IDX;
            codeQ <= sacBitMask(MSB_IDX);
          end
        end
        SAC_BITS: begin
          if (cv.tick) begin
            codeQ <= cv.cmp ? codeQ : (codeQ & ~sacBitMask(idxQ));
            if (idxQ == LSB_IDX) begin
              stateQ <= SAC_TAIL;
              idxQ <= 4'h0;
            end else begin
              idxQ <= idxQ - 4'h1;
              codeQ <= (cv.cmp ? codeQ : (codeQ & ~sacBitMask(idxQ)))
                       | sacBitMask(idxQ - 4'h1);
            end
          end
        end
        SAC_TAIL: begin
          if (cv.tick) begin
            if (idxQ == TAIL_LAST) begin
              stateQ <= SAC_IDLE;
              doneQ <= 1'b1;
            end else begin
              idxQ <= idxQ + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  logic [4:0] tickCnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt <= 5'h00;
    end else if (cv.en && cv.start && stateQ == SAC_IDLE) begin
      tickCnt <= 5'h00;
    end else if (cv.en && cv.tick && stateQ != SAC_IDLE) begin
      tickCnt <= tickCnt + 5'h01;
    end
  end

  a_msb_first: assert property (@(posedge clk) disable iff (sys_rst)
    cv.en && cv.tick && stateQ == SAC_SAMPLE |=> codeQ == 12'h800)
    else $error("First trial code is not the top bit.");

  a_bit_keep: assert property (@(posedge clk) disable iff (sys_rst)
    cv.en && cv.tick && stateQ == SAC_BITS && cv.cmp |=>
      (codeQ & sacBitMask($past(idxQ))) != 12'h000)
    else $error("Kept bit was cleared.");

  a_conv_length: assert property (@(posedge clk) disable iff (sys_rst)
    doneQ |-> tickCnt == 5'h10)
    else $error("Conversion did not take sixteen ticks.");

endmodule

// >>> sac_far_model.sv
`timescale 1ns/1ps
// ************************************************************
// Comparator and result reader on the far side.
// ************************************************************
module sac_far_model
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic [RES_BITS-1:0] dacCode,
  input wire logic frameEnd,
  input wire logic [RES_BITS-1:0] level,
  input wire logic dmaEn,
  output logic cmpIn,
  output logic resultRead,
  output int reads
);
  int lagQ;
  initial begin
    resultRead = 1'b0;
    reads = 0;
    lagQ = 0;
  end
  assign cmpIn = (level >= dacCode);
  always @(posedge clk) begin
    #1;
    if (resultRead) begin
      resultRead = 1'b0;
    end else if (dmaEn && frameEnd) begin
      if (lagQ == 3) begin
        resultRead = 1'b1;
        reads++;
        lagQ = 0;
      end else begin
        lagQ++;
      end
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import sac_pkg::*;
  // ************************************************************
  // Signals, design and far side.
  // ************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic swStart = 1'b0;
  logic frameStart = 1'b0;
  logic oneShot = 1'b1;
  logic wakeUp = 1'b0;
  logic dmaEn = 1'b0;
  logic [11:0] lvl = 12'h000;
  logic cmpIn, resultRead, convBusy, doneStatus, frameEnd, adcReady;
  logic [11:0] dacCode, result;
  int reads, bad_count = 0, n_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  sac_adc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .swStart(swStart),
    .frameStart(frameStart), .oneShot(oneShot), .wakeUp(wakeUp), .cmpIn(cmpIn),
    .resultRead(resultRead), .dacCode(dacCode), .result(result), .convBusy(convBusy),
    .doneStatus(doneStatus), .frameEnd(frameEnd), .adcReady(adcReady));
  sac_far_model far (.clk(clk), .dacCode(dacCode), .frameEnd(frameEnd), .level(lvl),
    .dmaEn(dmaEn), .cmpIn(cmpIn), .resultRead(resultRead), .reads(reads));
  // ************************************************************
  // Shared tasks.
  // ************************************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      stop_test();
    end
  end
  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic waitReady(input int frz);
    int n;
    logic busySeen;
    n = 0;
    busySeen = 1'b0;
    while (adcReady !== 1'b1 && n < 400) begin
      if (n == 5) swStart = 1'b1;
      if (n == 6) swStart = 1'b0;
      if (frz > 0 && n == 20) clkEn = 1'b0;
      if (frz > 0 && n == 20 + frz) clkEn = 1'b1;
      tick(1);
      n++;
      busySeen = busySeen | (convBusy === 1'b1);
    end
    chk(12'(busySeen), 12'h000);
    chk(12'(n >= 249 + frz && n <= 250 + frz), 12'h001);
  endtask
  task automatic oneConv(input logic [11:0] v, input logic useFrame, input int frz);
    int n;
    logic [11:0] first;
    lvl = v;
    n = 0;
    first = 12'h000;
    if (useFrame) frameStart = 1'b1;
    else swStart = 1'b1;
    tick(1);
    frameStart = 1'b0;
    swStart = 1'b0;
    while (frameEnd !== 1'b1 && n < 100) begin
      if (frz > 0 && n == 10) clkEn = 1'b0;
      if (frz > 0 && n == 10 + frz) clkEn = 1'b1;
      tick(1);
      n++;
      if (first === 12'h000 && dacCode !== 12'h000) first = dacCode;
    end
    chk(first, 12'h800);
    chk(12'(n >= 30 + frz && n <= 40 + frz), 12'h001);
    chk(result, v);
    chk(12'(doneStatus), 12'h001);
    tick(12);
    chk(12'(frameEnd), 12'h001);
    dmaEn = 1'b1;
    tick(8);
    chk(12'(frameEnd), 12'h000);
    chk(12'(doneStatus), 12'h000);
    dmaEn = 1'b0;
    tick(60);
    chk(12'({convBusy, frameEnd}), 12'h000);
  endtask
  task automatic contRun();
    int r;
    r = reads;
    lvl = 12'h3c7;
    dmaEn = 1'b1;
    oneShot = 1'b0;
    swStart = 1'b1;
    tick(1);
    swStart = 1'b0;
    tick(200);
    chk(12'(reads - r >= 5), 12'h001);
    chk(result, 12'h3c7);
    oneShot = 1'b1;
    tick(80);
    r = reads;
    tick(80);
    chk(12'(reads - r), 12'h000);
    chk(12'(convBusy), 12'h000);
    dmaEn = 1'b0;
  endtask
  task automatic midReset();
    swStart = 1'b1;
    tick(1);
    swStart = 1'b0;
    tick(10);
    chk(12'(convBusy), 12'h001);
    sys_rst = 1'b1;
    tick(2);
    chk(12'({convBusy, doneStatus, frameEnd, adcReady}), 12'h000);
    chk(result | dacCode, 12'h000);
    sys_rst = 1'b0;
    waitReady(0);
  endtask
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    tick(4);
    sys_rst = 1'b0;
    waitReady(0);
    oneConv(12'ha5c, 1'b0, 0);
    oneConv(12'hfff, 1'b1, 0);
    oneConv(12'h000, 1'b0, 0);
    contRun();
    wakeUp = 1'b1;
    tick(1);
    wakeUp = 1'b0;
    chk(12'(adcReady), 12'h000);
    waitReady(10);
    oneConv(12'h555, 1'b1, 8);
    midReset();
    oneConv(12'h2e1, 1'b0, 0);
    stop_test();
  end
endmodule
